/* File: core/branch_sequencer.sv */
// Branch, jump, call and return sequencer: decode, target and cycle timing.
// Operation
// - branch_no_carry: 2 bytes, 2/3 cycles, jumps carry clear
// - jump_on_bit_set: 3 bytes, 3/4 cycles, bit one
// - branch_bit_clear: 3 bytes, 3/4 cycles, bit zero
// - branch_bit_set_clear: bit one, clear it, 3/4
// - page_call: 11-bit target, 2 bytes, 3 cycles
// - long_call: 16-bit target, 3 bytes, 4 cycles
// - subroutine_exit: 1 byte, 5 cycles
// - interrupt_exit: 1 byte, 5 cycles
// - page_jump: 11-bit target, 2 bytes, 3 cycles
// - long_jump: 16-bit target, 3 bytes, 4 cycles
// - short_jump: relative target, 2 bytes, 3 cycles
// - indirect_jump to accumulator plus data_pointer, 1/3
// - branch_acc_zero: 2 bytes, 2/3 cycles
// - branch_acc_nonzero: 2 bytes, 2/3 cycles
// - compare accumulator with direct byte: 3 bytes, 4/5
// - compare accumulator with immediate: 3 bytes, 3/4
// - compare register with immediate: 3 bytes, 3/4
// - compare indirect byte with immediate: 3 bytes, 3/4
// - decrement register, branch nonzero: 2 bytes, 2/3
// - decrement direct byte, branch nonzero: 3 bytes, 3/4
`timescale 1ns/1ps
module branch_sequencer (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 op_valid,
  input  wire branch_pkg::op_kind_e op_kind,
  input  wire logic [15:0]          op_pc,
  input  wire logic [2:0]           op_page_bits,
  input  wire logic [7:0]           op_byte1,
  input  wire logic [7:0]           op_byte2,
  input  wire logic                 carry,
  input  wire logic                 bit_val,
  input  wire logic [7:0]           acc,
  input  wire logic [15:0]          data_pointer,
  input  wire logic [7:0]           direct_val,
  input  wire logic [7:0]           reg_val,
  input  wire logic [7:0]           ind_val,
  input  wire logic [15:0]          stack_ret,
  output logic                      op_ready,
  output logic                      done,
  output logic                      taken,
  output logic [15:0]               next_pc,
  output logic [1:0]                instr_len,
  output logic [2:0]                instr_cycles,
  output logic                      bit_clear,
  output logic                      wb_en,
  output logic [7:0]                wb_val,
  output logic                      push_en,
  output logic [15:0]               push_addr,
  output logic                      pop_en,
  output logic                      irq_exit
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode functions.

  // Encoded length of each kind.
  function automatic logic [1:0] len_of(input branch_pkg::op_kind_e k);
    case (k)
      branch_pkg::SUBROUTINE_EXIT, branch_pkg::INTERRUPT_EXIT,
      branch_pkg::INDIRECT_JUMP: len_of = branch_pkg::LEN_1;
      branch_pkg::BRANCH_NO_CARRY, branch_pkg::PAGE_CALL, branch_pkg::PAGE_JUMP,
      branch_pkg::SHORT_JUMP, branch_pkg::BRANCH_ACC_ZERO, branch_pkg::BRANCH_ACC_NONZERO,
      branch_pkg::DBN_REG: len_of = branch_pkg::LEN_2;
      default: len_of = branch_pkg::LEN_3;
    endcase
  endfunction

  // Cycle count of each kind; conditional kinds add one when taken.
  function automatic logic [2:0] cyc_of(input branch_pkg::op_kind_e k, input logic tk);
    case (k)
      branch_pkg::BRANCH_NO_CARRY, branch_pkg::BRANCH_ACC_ZERO,
      branch_pkg::BRANCH_ACC_NONZERO, branch_pkg::DBN_REG:
        cyc_of = tk ? branch_pkg::CYC_3 : branch_pkg::CYC_2;
      branch_pkg::JUMP_ON_BIT_SET, branch_pkg::BRANCH_BIT_CLEAR, branch_pkg::BRANCH_BIT_SET_CLEAR,
      branch_pkg::CBU_ACC_IMM, branch_pkg::CBU_REG_IMM, branch_pkg::CBU_IND_IMM, branch_pkg::DBN_DIRECT:
        cyc_of = tk ? branch_pkg::CYC_4 : branch_pkg::CYC_3;
      branch_pkg::CBU_ACC_DIRECT:
        cyc_of = tk ? branch_pkg::CYC_5 : branch_pkg::CYC_4;
      branch_pkg::PAGE_CALL, branch_pkg::PAGE_JUMP, branch_pkg::SHORT_JUMP,
      branch_pkg::INDIRECT_JUMP: cyc_of = branch_pkg::CYC_3;
      branch_pkg::LONG_CALL, branch_pkg::LONG_JUMP: cyc_of = branch_pkg::CYC_4;
      default: cyc_of = branch_pkg::CYC_5;
    endcase
  endfunction

  // True for kinds whose outcome depends on a condition.
  function automatic logic is_cond(input branch_pkg::op_kind_e k);
    case (k)
      branch_pkg::PAGE_CALL, branch_pkg::LONG_CALL, branch_pkg::SUBROUTINE_EXIT,
      branch_pkg::INTERRUPT_EXIT, branch_pkg::PAGE_JUMP, branch_pkg::LONG_JUMP,
      branch_pkg::SHORT_JUMP, branch_pkg::INDIRECT_JUMP: is_cond = 1'b0;
      default: is_cond = 1'b1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Condition and target evaluation.

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } seq_state_e;

  seq_state_e  state_r;
  seq_state_e  state_nxt;
  logic        accept;
  logic        cond;
  logic        go;
  logic [1:0]  len_w;
  logic [2:0]  cyc_w;
  logic [15:0] seq_pc;
  logic [7:0]  rel_byte;
  logic [15:0] rel_target;
  logic [15:0] page_target;
  logic [15:0] long_target;
  logic [15:0] target;
  logic [7:0]  dec_src;
  logic [7:0]  dec_res;
  logic        is_dec;

  // The decrement works on a register or a direct byte, and the branch tests its result.
  assign is_dec  = (op_kind == branch_pkg::DBN_REG) || (op_kind == branch_pkg::DBN_DIRECT);
  assign dec_src = (op_kind == branch_pkg::DBN_REG) ? reg_val : direct_val;
  assign dec_res = dec_src - branch_pkg::BYTE_ONE;

  // Branch condition per kind; unconditional kinds always transfer control.
  always_comb begin
    case (op_kind)
      branch_pkg::BRANCH_NO_CARRY:      cond = !carry;
      branch_pkg::JUMP_ON_BIT_SET:      cond = bit_val;
      branch_pkg::BRANCH_BIT_CLEAR:     cond = !bit_val;
      branch_pkg::BRANCH_BIT_SET_CLEAR: cond = bit_val;
      branch_pkg::BRANCH_ACC_ZERO:      cond = (acc == branch_pkg::BYTE_ZERO);
      branch_pkg::BRANCH_ACC_NONZERO:   cond = (acc != branch_pkg::BYTE_ZERO);
      branch_pkg::CBU_ACC_DIRECT:       cond = (acc != direct_val);
      branch_pkg::CBU_ACC_IMM:          cond = (acc != op_byte1);
      branch_pkg::CBU_REG_IMM:          cond = (reg_val != op_byte1);
      branch_pkg::CBU_IND_IMM:          cond = (ind_val != op_byte1);
      branch_pkg::DBN_REG, branch_pkg::DBN_DIRECT:
                                        cond = (dec_res != branch_pkg::BYTE_ZERO);
      default:                          cond = 1'b1;
    endcase
  end

  // The offset sits in the last byte of the instruction and counts from the next one.
  assign len_w       = len_of(op_kind);
  assign go          = is_cond(op_kind) ? cond : 1'b1;
  assign cyc_w       = cyc_of(op_kind, go);
  assign seq_pc      = op_pc + {14'h0000, len_w};
  assign rel_byte    = (len_w == branch_pkg::LEN_3) ? op_byte2 : op_byte1;
  assign rel_target  = seq_pc + {{8{rel_byte[7]}}, rel_byte};
  assign page_target = {seq_pc[branch_pkg::ADDR_W-1:branch_pkg::PAGE_LO], op_page_bits, op_byte1};
  assign long_target = {op_byte1, op_byte2};

  // Selection of the new program counter.
  always_comb begin
    case (op_kind)
      branch_pkg::PAGE_CALL, branch_pkg::PAGE_JUMP:      target = page_target;
      branch_pkg::LONG_CALL, branch_pkg::LONG_JUMP:      target = long_target;
      branch_pkg::SUBROUTINE_EXIT, branch_pkg::INTERRUPT_EXIT: target = stack_ret;
      branch_pkg::INDIRECT_JUMP: target = data_pointer + {8'h00, acc};
      default:                   target = go ? rel_target : seq_pc;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and timing.

  cycle_timer_if tif ();

  cycle_timer u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tif      (tif)
  );

  // The first cycle is the accept cycle, so the timer covers the rest.
  assign accept       = op_valid && (state_r == ST_IDLE || state_r == ST_DONE);
  assign tif.load     = accept;
  assign tif.load_val = cyc_w - branch_pkg::CNT_ONE;

  // Next state: a new instruction may start in the same cycle that done shows.
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = accept ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = tif.last ? ST_DONE : ST_EXEC;
      ST_DONE: state_nxt = accept ? ST_EXEC : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  logic        taken_r;
  logic [15:0] pc_r;
  logic [1:0]  len_r;
  logic [2:0]  cyc_r;
  logic        bclr_r;
  logic        wb_r;
  logic [7:0]  wbv_r;
  logic        push_r;
  logic [15:0] pusha_r;
  logic        pop_r;
  logic        iexit_r;
  logic        done_r;
  logic        ready_r;
  logic        fire;

  // Side effects are held until the last cycle so that all land with done.
  assign fire = (state_r == ST_EXEC) && tif.last;

  // State and ready flags.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      done_r  <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      done_r  <= fire;
      ready_r <= (state_nxt != ST_EXEC);
    end
  end

  // Result latch at accept; these stand until the next accept.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      taken_r <= 1'b0;
      pc_r    <= branch_pkg::ADDR_ZERO;
      len_r   <= branch_pkg::LEN_1;
      cyc_r   <= branch_pkg::CYC_2;
      wbv_r   <= branch_pkg::BYTE_ZERO;
      pusha_r <= branch_pkg::ADDR_ZERO;
    end else if (accept) begin
      taken_r <= go;
      pc_r    <= target;
      len_r   <= len_w;
      cyc_r   <= cyc_w;
      wbv_r   <= dec_res;
      pusha_r <= seq_pc;
    end
  end

  // Kind flags for the one-cycle side-effect strobes.
  logic is_bclr_r;
  logic is_dec_r;
  logic is_call_r;
  logic is_ret_r;
  logic is_iret_r;

  // Kind flags latched at accept.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      is_bclr_r <= 1'b0;
      is_dec_r  <= 1'b0;
      is_call_r <= 1'b0;
      is_ret_r  <= 1'b0;
      is_iret_r <= 1'b0;
    end else if (accept) begin
      is_bclr_r <= (op_kind == branch_pkg::BRANCH_BIT_SET_CLEAR) && bit_val;
      is_dec_r  <= is_dec;
      is_call_r <= (op_kind == branch_pkg::PAGE_CALL) || (op_kind == branch_pkg::LONG_CALL);
      is_ret_r  <= (op_kind == branch_pkg::SUBROUTINE_EXIT) || (op_kind == branch_pkg::INTERRUPT_EXIT);
      is_iret_r <= (op_kind == branch_pkg::INTERRUPT_EXIT);
    end
  end

  // Strobes, one cycle wide, in the cycle that done shows.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bclr_r  <= 1'b0;
      wb_r    <= 1'b0;
      push_r  <= 1'b0;
      pop_r   <= 1'b0;
      iexit_r <= 1'b0;
    end else begin
      bclr_r  <= fire && is_bclr_r;
      wb_r    <= fire && is_dec_r;
      push_r  <= fire && is_call_r;
      pop_r   <= fire && is_ret_r;
      iexit_r <= fire && is_iret_r;
    end
  end

  assign op_ready     = ready_r;
  assign done         = done_r;
  assign taken        = taken_r;
  assign next_pc      = pc_r;
  assign instr_len    = len_r;
  assign instr_cycles = cyc_r;
  assign bit_clear    = bclr_r;
  assign wb_en        = wb_r;
  assign wb_val       = wbv_r;
  assign push_en      = push_r;
  assign push_addr    = pusha_r;
  assign pop_en       = pop_r;
  assign irq_exit     = iexit_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_acc(branch_pkg::op_kind_e k);
    accept && op_kind == k;
  endsequence

  // A five-cycle instruction stays busy for four cycles and then shows done.
  sequence s_busy_then_done;
    (!done && !op_ready) [*4] ##1 done;
  endsequence

  AST_NO_CARRY_TAKEN: assert property (
    s_acc(branch_pkg::BRANCH_NO_CARRY) and (accept && !carry) |-> ##3 done ##0 taken && instr_cycles == 3'h3)
    else $error("carry-clear branch not done in 3 cycles");
  AST_NO_CARRY_SKIP: assert property (
    s_acc(branch_pkg::BRANCH_NO_CARRY) and (accept && carry) |-> ##2 done ##0 !taken && instr_len == 2'h2)
    else $error("carry-set branch not done in 2 cycles");
  AST_BIT_SET_CLEAR: assert property (
    s_acc(branch_pkg::BRANCH_BIT_SET_CLEAR) and (accept && bit_val) |-> ##4 (done && bit_clear && taken))
    else $error("bit not cleared on taken bit branch");
  AST_RETURN_TIME: assert property (
    s_acc(branch_pkg::SUBROUTINE_EXIT) |-> ##1 s_busy_then_done ##0 (pop_en && !irq_exit && instr_len == 2'h1))
    else $error("return not five cycles");
  AST_IRET_TIME: assert property (
    s_acc(branch_pkg::INTERRUPT_EXIT) |-> ##1 s_busy_then_done ##0 (pop_en && irq_exit && instr_len == 2'h1))
    else $error("interrupt return not five cycles");
  AST_LONG_CALL: assert property (
    s_acc(branch_pkg::LONG_CALL) |-> ##4 (done && push_en && next_pc == $past(long_target, 4)))
    else $error("long call target or timing wrong");
  AST_CMP_DIRECT: assert property (
    s_acc(branch_pkg::CBU_ACC_DIRECT) and (accept && acc != direct_val) |-> ##5 done && instr_cycles == 3'h5)
    else $error("compare direct taken not five cycles");
  AST_SHORT_JUMP: assert property (
    s_acc(branch_pkg::SHORT_JUMP) |-> ##3 (done && next_pc == $past(rel_target, 3)))
    else $error("short jump target or timing wrong");
  AST_DEC_WRITE: assert property (
    s_acc(branch_pkg::DBN_REG) ##0 (reg_val != 8'h01) |->
      ##3 (done && wb_en && taken && wb_val == $past(reg_val, 3) - 8'h01))
    else $error("taken decrement write-back wrong");
  AST_DEC_SKIP: assert property (
    s_acc(branch_pkg::DBN_REG) ##0 (reg_val == 8'h01) |-> ##2 (done && wb_en && !taken && wb_val == 8'h00))
    else $error("untaken decrement write-back wrong");
  AST_NOT_TAKEN_SHORT: assert property (
    done && is_cond(branch_pkg::op_kind_e'(5'h00)) && !taken && instr_len == 2'h2 |-> instr_cycles == 3'h2)
    else $error("untaken two-byte branch not minimal cycles");

endmodule

/* File: core/branch_pkg.sv */
// Shared kinds, lengths, cycle counts and widths of the branch sequencer.
package branch_pkg;

  // Instruction kinds handed over by the front decoder.
  typedef enum logic [4:0] {
    BRANCH_NO_CARRY      = 5'h00,
    JUMP_ON_BIT_SET      = 5'h01,
    BRANCH_BIT_CLEAR     = 5'h02,
    BRANCH_BIT_SET_CLEAR = 5'h03,
    PAGE_CALL            = 5'h04,
    LONG_CALL            = 5'h05,
    SUBROUTINE_EXIT      = 5'h06,
    INTERRUPT_EXIT       = 5'h07,
    PAGE_JUMP            = 5'h08,
    LONG_JUMP            = 5'h09,
    SHORT_JUMP           = 5'h0A,
    INDIRECT_JUMP        = 5'h0B,
    BRANCH_ACC_ZERO      = 5'h0C,
    BRANCH_ACC_NONZERO   = 5'h0D,
    CBU_ACC_DIRECT       = 5'h0E,
    CBU_ACC_IMM          = 5'h0F,
    CBU_REG_IMM          = 5'h10,
    CBU_IND_IMM          = 5'h11,
    DBN_REG              = 5'h12,
    DBN_DIRECT           = 5'h13
  } op_kind_e;

  // Encoded lengths in bytes.
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Execution times in system clock cycles.
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_5 = 3'h5;

  // Widths and field positions.
  localparam int          ADDR_W    = 16;
  localparam int          PAGE_LO   = 11;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [2:0]  CNT_ZERO  = 3'h0;
  localparam logic [2:0]  CNT_ONE   = 3'h1;

endpackage

/* File: core/cycle_timer_if.sv */
// Load and expiry handshake between the sequencer and its cycle timer.
`timescale 1ns/1ps
interface cycle_timer_if;
  logic       load;
  logic [2:0] load_val;
  logic       last;

  modport seq   (output load, output load_val, input last);
  modport timer (input load, input load_val, output last);
endinterface

/* File: core/cycle_timer.sv */
// Down counter that marks the last busy cycle of an instruction.
`timescale 1ns/1ps
module cycle_timer (
  input wire logic   core_clk,
  input wire logic   nrst,
  cycle_timer_if.timer tif
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // A load replaces any count; otherwise the count runs down to zero and rests.
  assign cnt_nxt  = tif.load ? tif.load_val :
                    (cnt_r == branch_pkg::CNT_ZERO) ? branch_pkg::CNT_ZERO : cnt_r - branch_pkg::CNT_ONE;
  assign tif.last = !tif.load && (cnt_r == branch_pkg::CNT_ONE);

  // Counter register.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= branch_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // After a load of n the expiry shows n cycles later.
  AST_TIMER_EXPIRY: assert property (@(posedge core_clk) disable iff (!nrst)
    tif.load && tif.load_val == branch_pkg::CYC_3 |-> !tif.last ##1 !tif.last ##1 !tif.last ##1 tif.last)
    else $error("timer expiry not three cycles after load");

endmodule

/* File: verification/tb.sv */
// Self-checking bench for the branch sequencer: lengths, cycle counts, targets and side effects.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic        tk;
    logic [15:0] npc;
    logic [15:0] pa;
    logic [1:0]  len;
    logic [2:0]  cyc;
    logic        bclr;
    logic        wben;
    logic [7:0]  wbv;
    logic        push;
    logic        pop;
    logic        irq;
    logic [31:0] at;
  } exp_s;

  logic                 core_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 op_valid = 1'b0;
  branch_pkg::op_kind_e op_kind = branch_pkg::BRANCH_NO_CARRY;
  logic [15:0]          op_pc = 16'h0000;
  logic [2:0]           op_page_bits = 3'h0;
  logic [7:0]           op_byte1 = 8'h00;
  logic [7:0]           op_byte2 = 8'h00;
  logic                 carry = 1'b0;
  logic                 bit_val = 1'b0;
  logic [7:0]           acc = 8'h00;
  logic [15:0]          data_pointer = 16'h0000;
  logic [7:0]           direct_val = 8'h00;
  logic [7:0]           reg_val = 8'h00;
  logic [7:0]           ind_val = 8'h00;
  logic [15:0]          stack_ret = 16'h0000;
  logic                 op_ready, done, taken, bit_clear, wb_en, push_en, pop_en, irq_exit;
  logic [15:0]          next_pc, push_addr;
  logic [1:0]           instr_len;
  logic [2:0]           instr_cycles;
  logic [7:0]           wb_val;
  logic [31:0]          cyc_cnt = 32'h0;
  int                   err_count = 0;
  int                   samples_checked = 0;
  exp_s                 q [$];
  // Byte lengths and cycle counts without the extra taken cycle of conditional kinds, indexed by kind code.
  logic [1:0] len_tab [0:19] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h1, 2'h1, 2'h2, 2'h3,
                                 2'h2, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3};
  logic [2:0] cyc_tab [0:19] = '{3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h3, 3'h4,
                                 3'h3, 3'h3, 3'h2, 3'h2, 3'h4, 3'h3, 3'h3, 3'h3, 3'h2, 3'h3};

  branch_sequencer DUT (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .op_valid     (op_valid),
    .op_kind      (op_kind),
    .op_pc        (op_pc),
    .op_page_bits (op_page_bits),
    .op_byte1     (op_byte1),
    .op_byte2     (op_byte2),
    .carry        (carry),
    .bit_val      (bit_val),
    .acc          (acc),
    .data_pointer (data_pointer),
    .direct_val   (direct_val),
    .reg_val      (reg_val),
    .ind_val      (ind_val),
    .stack_ret    (stack_ret),
    .op_ready     (op_ready),
    .done         (done),
    .taken        (taken),
    .next_pc      (next_pc),
    .instr_len    (instr_len),
    .instr_cycles (instr_cycles),
    .bit_clear    (bit_clear),
    .wb_en        (wb_en),
    .wb_val       (wb_val),
    .push_en      (push_en),
    .push_addr    (push_addr),
    .pop_en       (pop_en),
    .irq_exit     (irq_exit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a free cycle count used to time each instruction.
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc_cnt <= cyc_cnt + 32'h1;

  // Compares one value; case inequality so an unknown never counts as a match.
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] t=%0t seen=%0h expected=%0h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Drives one instruction and notes its expected result. The request stays up
  // after acceptance so the next call overlaps the busy window, which must be ignored.
  task automatic issue(input int i, input logic t);
    logic [15:0] pc, dp, sr, fall, r1, r2, tgt;
    logic [7:0]  b1, b2, a, dv, rv, iv;
    logic [2:0]  pg;
    logic        c, bv, cond;
    exp_s        e;
    int          n;
    pc = 16'($urandom); dp = 16'($urandom); sr = 16'($urandom); pg = 3'($urandom);
    b1 = 8'($urandom); b2 = 8'($urandom); a = 8'($urandom); dv = 8'($urandom);
    rv = 8'($urandom); iv = 8'($urandom); c = 1'($urandom); bv = 1'($urandom);
    fall = pc + {14'h0, len_tab[i]};
    r1 = fall + {{8{b1[7]}}, b1};
    r2 = fall + {{8{b2[7]}}, b2};
    e = '0;
    cond = 1'b1;
    tgt = r2;
    // Operands of conditional kinds are steered so that the outcome equals t; the outcome is then derived from them.
    case (i)
      0: begin c = !t; e.tk = !c; tgt = r1; end
      1: begin bv = t; e.tk = bv; end
      2: begin bv = !t; e.tk = !bv; end
      3: begin bv = t; e.tk = bv; e.bclr = bv; end
      4, 8: begin cond = 1'b0; tgt = {fall[15:11], pg, b1}; e.push = (i == 4); end
      5, 9: begin cond = 1'b0; tgt = {b1, b2}; e.push = (i == 5); end
      6, 7: begin cond = 1'b0; tgt = sr; e.pop = 1'b1; e.irq = (i == 7); end
      10: begin cond = 1'b0; tgt = r1; end
      11: begin cond = 1'b0; tgt = dp + {8'h00, a}; end
      12: begin a = t ? 8'h00 : (a | 8'h01); e.tk = (a == 8'h00); tgt = r1; end
      13: begin a = t ? (a | 8'h01) : 8'h00; e.tk = (a != 8'h00); tgt = r1; end
      14: begin dv = t ? ~a : a; e.tk = (a != dv); end
      15: begin b1 = t ? ~a : a; e.tk = (a != b1); end
      16: begin b1 = t ? ~rv : rv; e.tk = (rv != b1); end
      17: begin b1 = t ? ~iv : iv; e.tk = (iv != b1); end
      18: begin rv = t ? 8'h00 : 8'h01; e.wbv = rv - 8'h01; tgt = r1; end
      default: begin dv = t ? 8'h00 : 8'h01; e.wbv = dv - 8'h01; end
    endcase
    if (i >= 18) begin
      e.wben = 1'b1;
      e.tk = (e.wbv != 8'h00);
    end
    if (!cond) begin
      e.tk = 1'b1;
    end
    e.len = len_tab[i];
    e.cyc = cyc_tab[i] + {2'h0, cond & e.tk};
    e.npc = e.tk ? tgt : fall;
    e.pa = fall;
    op_valid <= 1'b1;
    op_kind <= branch_pkg::op_kind_e'(i[4:0]);
    op_pc <= pc; op_page_bits <= pg; op_byte1 <= b1; op_byte2 <= b2;
    carry <= c; bit_val <= bv; acc <= a; data_pointer <= dp;
    direct_val <= dv; reg_val <= rv; ind_val <= iv; stack_ret <= sr;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (op_ready === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      end_sim();
    end
    e.at = cyc_cnt;
    q.push_back(e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watches the outputs; each completion retires the oldest note.
  always @(negedge core_clk) begin
    exp_s m;
    if (nrst === 1'b1 && done === 1'b1) begin
      if (q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        m = q.pop_front();
        chk(cyc_cnt - m.at, {29'h0, m.cyc});
        chk(instr_cycles, m.cyc);
        chk(instr_len, m.len);
        chk(taken, m.tk);
        chk(next_pc, m.npc);
        chk(bit_clear, m.bclr);
        chk({push_en, pop_en, irq_exit}, {m.push, m.pop, m.irq});
        chk(wb_en, m.wben);
        if (m.wben) chk(wb_val, m.wbv);
        if (m.push) chk(push_addr, m.pa);
      end
    end else if (nrst === 1'b1) begin
      chk({bit_clear, wb_en, push_en, pop_en, irq_exit}, 32'h0);
    end
  end

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, then every conditional kind taken and untaken and every other kind taken, back to back.
  initial begin
    int n;
    void'($urandom(32'hFC83));
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk({op_ready, done, next_pc, instr_len, instr_cycles}, {1'b1, 1'b0, 16'h0000, 2'h1, 3'h2});
    $display("test reset values done");
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 20; i++) begin
        issue(i, 1'b0);
        issue(i, 1'b1);
      end
      op_valid <= 1'b0;
      for (n = 0; n < 200; n++) begin
        @(posedge core_clk);
        if (q.size() == 0) break;
      end
      if (n == 200) begin
        err_count++;
        end_sim();
      end
      $display("test round %0d of all kinds done", r);
    end
    repeat (4) @(posedge core_clk);
    end_sim();
  end
endmodule
